/* File: bff_burst_fluxbal_ff.sv */
// The implementer's own choices: the register addresses and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`include "bff_consts.svh"
module bff_burst_fluxbal_ff (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic [4:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [11:0] rect_sense_pin_a,
   input wire logic [11:0] rect_sense_pin_b,
   input wire logic [11:0] primary_vin_sense_pin,
   input wire logic [11:0] vout_sense_pin,
   input wire logic [11:0] iout_sense,
   input wire logic rect_edge_cmp,
   input wire logic [7:0] pid_duty,
   output logic prim_even,
   output logic prim_odd,
   output logic sr_even,
   output logic sr_odd,
   output logic burst_enable
);
   // clamp a signed width to 0..half period
   function automatic logic [6:0] sat_half(input logic signed [19:0] v);
      if (v < 0) return 7'h00;
      if (v > $signed(20'(`BFF_HALF))) return 7'(`BFF_HALF);
      return v[6:0];
   endfunction : sat_half

   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!reset_n);

   logic wait_ff, lock_ff, tonly_ff, bmode_ff, topo_ff, vmode_ff, burst_en_ff;
   logic [1:0] src_ff, reps_ff;
   logic [3:0] err_thr_ff, reps_cnt_ff;
   logic [7:0] pmode_ff, kp_ff, ki_ff, ith_ff;
   logic [11:0] ovr_ff, target_ff, dcm_thr_ff, vin_ff, vin_last_ff;
   logic [31:0] rdata_ff;
   bff_pkg::bff_state_t st_ff, nxt_st;

   // bus slave: one wait cycle, then the access completes
   wire req = avs_read | avs_write;
   wire acc = req & ~wait_ff;
   wire wr = avs_write & acc;
   wire sel_ctrl = avs_address == `BFF_OFF_CTRL;
   wire sel_pmode = avs_address == `BFF_OFF_PMODE;
   wire sel_ovr = avs_address == `BFF_OFF_OVR;
   wire sel_gain = avs_address == `BFF_OFF_GAIN;
   wire sel_burst = avs_address == `BFF_OFF_BURST;
   wire sel_tgt = avs_address == `BFF_OFF_TARGET;
   wire sel_dcm = avs_address == `BFF_OFF_DCM;
   wire sel_stat = avs_address == `BFF_OFF_STAT;
   wire fbal_active;
   wire dcm;
   wire [1:0] st_code = st_ff == bff_pkg::BFF_RUN ? 2'h0 : (st_ff == bff_pkg::BFF_IDLE ? 2'h1 : 2'h2);
   wire [31:0] rd_mux =
      sel_ctrl ? {25'h0, vmode_ff, topo_ff, bmode_ff, tonly_ff, lock_ff, src_ff} :
      sel_pmode ? {24'h0, pmode_ff} :
      sel_ovr ? {20'h0, ovr_ff} :
      sel_gain ? {16'h0, ki_ff, kp_ff} :
      sel_burst ? {18'h0, reps_ff, err_thr_ff, ith_ff} :
      sel_tgt ? {20'h0, target_ff} :
      sel_dcm ? {20'h0, dcm_thr_ff} :
      sel_stat ? {4'h0, vin_ff, 11'h0, fbal_active, dcm, burst_en_ff, st_code} : 32'h0000_0000;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         wait_ff <= 1'b1;
         rdata_ff <= 32'h0000_0000;
      end else begin
         wait_ff <= ~(req & wait_ff);
         if (req & wait_ff) rdata_ff <= rd_mux; // unmapped reads give zero
      end
   end

   // control fields; writes to unmapped or status offsets are dropped
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {src_ff, lock_ff, tonly_ff, bmode_ff, topo_ff, vmode_ff} <= 7'h00;
         pmode_ff <= `BFF_PMODE_RST;
         {ovr_ff, target_ff, dcm_thr_ff} <= 36'h0_0000_0000;
         {kp_ff, ki_ff, ith_ff} <= 24'h00_0000;
         {err_thr_ff, reps_ff} <= 6'h00;
      end else begin
         if (wr & sel_ctrl) begin
            src_ff <= avs_writedata[`BFF_CTRL_SRC];
            lock_ff <= avs_writedata[`BFF_CTRL_LOCK];
            tonly_ff <= avs_writedata[`BFF_CTRL_TONLY];
            bmode_ff <= avs_writedata[`BFF_CTRL_BMODE];
            topo_ff <= avs_writedata[`BFF_CTRL_TOPO_FB];
            vmode_ff <= avs_writedata[`BFF_CTRL_VMODE];
         end
         if (wr & sel_pmode) pmode_ff <= avs_writedata[7:0];
         if (wr & sel_ovr) ovr_ff <= avs_writedata[11:0];
         if (wr & sel_gain) {ki_ff, kp_ff} <= avs_writedata[15:0];
         if (wr & sel_burst) begin
            ith_ff <= avs_writedata[`BFF_BURST_ITH];
            err_thr_ff <= avs_writedata[`BFF_BURST_ERR]; // 4 bits: 0 to 15 steps of 1.25 mV R15
            reps_ff <= avs_writedata[`BFF_BURST_REPS];
         end
         if (wr & sel_tgt) target_ff <= avs_writedata[11:0];
         if (wr & sel_dcm) dcm_thr_ff <= avs_writedata[11:0];
      end
   end

   // comparator pin: three stages, level accepted when the last two agree
   logic rs1_ff, rs2_ff, rs3_ff, rect_hi_ff;
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         {rs1_ff, rs2_ff, rs3_ff, rect_hi_ff} <= 4'h0;
      end else begin
         {rs1_ff, rs2_ff, rs3_ff} <= {rect_edge_cmp, rs1_ff, rs2_ff};
         if (rs2_ff == rs3_ff) rect_hi_ff <= rs3_ff;
      end
   end

   // phase counter of one switching period
   logic [6:0] ph_ff;
   wire tick = ph_ff == 7'(`BFF_PERIOD - 1);
   wire even = ph_ff < 7'(`BFF_HALF);
   wire [6:0] hp = even ? ph_ff : ph_ff - 7'(`BFF_HALF);

   // input voltage source select
   wire [11:0] vin_mux = src_ff == `BFF_SRC_A ? rect_sense_pin_a :
      src_ff == `BFF_SRC_B ? rect_sense_pin_b :
      src_ff == `BFF_SRC_PRI ? primary_vin_sense_pin : ovr_ff; // R1 R2
   wire [11:0] dv = vin_ff > vin_last_ff ? vin_ff - vin_last_ff : vin_last_ff - vin_ff;
   wire transient = dv > `BFF_FF_TRANS_THR;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         ph_ff <= 7'h00;
         vin_ff <= 12'h000;
         vin_last_ff <= 12'h000;
         burst_en_ff <= 1'b0;
      end else begin
         ph_ff <= tick ? 7'h00 : ph_ff + 7'h01;
         vin_ff <= vin_mux; // R1
         if (tick) vin_last_ff <= vin_ff;
         burst_en_ff <= pmode_ff == `BFF_PMODE_BURST; // R11
      end
   end

   // feed-forward divider: duty = (vout << 6) / vin, restoring, one bit a cycle
   logic [4:0] div_cnt_ff;
   logic [17:0] num_ff, quo_ff;
   logic [11:0] rem_ff, div_d_ff;
   logic [6:0] ff_duty_ff;
   logic ff_hold_ff;
   wire [12:0] trial = {rem_ff, num_ff[17]};
   wire ge = trial >= {1'b0, div_d_ff};
   wire [12:0] diff13 = trial - {1'b0, div_d_ff};
   wire [17:0] nxt_quo = {quo_ff[16:0], ge};
   wire div_start = tick & transient & (div_cnt_ff == 5'h00);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         div_cnt_ff <= 5'h00;
         {num_ff, quo_ff} <= 36'h0_0000_0000;
         {rem_ff, div_d_ff} <= 24'h00_0000;
         ff_duty_ff <= 7'h00;
         ff_hold_ff <= 1'b0;
      end else begin
         if (div_start) begin // R3
            div_cnt_ff <= `BFF_DIV_STEPS;
            num_ff <= {vout_sense_pin, 6'h00};
            div_d_ff <= vin_ff;
            rem_ff <= 12'h000;
            quo_ff <= 18'h0_0000;
         end else if (div_cnt_ff != 5'h00) begin
            div_cnt_ff <= div_cnt_ff - 5'h01;
            num_ff <= {num_ff[16:0], 1'b0};
            rem_ff <= ge ? diff13[11:0] : trial[11:0];
            quo_ff <= nxt_quo;
         end
         // the new duty holds for one period, then the loop takes over
         if (div_cnt_ff == 5'h01) begin
            ff_duty_ff <= sat_half({2'h0, nxt_quo}); // R3
            ff_hold_ff <= 1'b1;
         end else if (tick) begin
            ff_hold_ff <= 1'b0;
         end
      end
   end

   // burst state machine; every change lands on a period boundary
   wire low_i = {iout_sense, 1'b0} < {5'h00, ith_ff}; // R13
   wire signed [12:0] err_v = $signed({1'b0, target_ff}) - $signed({1'b0, vout_sense_pin});
   wire restart = err_v > $signed({9'h000, err_thr_ff}); // R14
   always_comb begin
      nxt_st = st_ff;
      if (tick) begin
         unique case (st_ff)
            bff_pkg::BFF_RUN: if (burst_en_ff & low_i) nxt_st = bff_pkg::BFF_IDLE; // R12 R19
            bff_pkg::BFF_IDLE: begin
               if (!burst_en_ff) nxt_st = bff_pkg::BFF_RUN; // R19
               else if (restart) nxt_st = bff_pkg::BFF_BURST; // R14
            end
            bff_pkg::BFF_BURST: begin
               // leaving burst mode mid-burst returns to the regulated loop at the next period boundary
               if (!burst_en_ff) nxt_st = bff_pkg::BFF_RUN; // R19
               else if (reps_cnt_ff == 4'h0) nxt_st = bff_pkg::BFF_IDLE;
            end
            // the spare state code falls back to the regulated loop
            default: nxt_st = bff_pkg::BFF_RUN;
         endcase
      end
   end

   // duty base and freeze; the frozen copy follows the loop until the state leaves run on burst entry
   wire run = st_ff == bff_pkg::BFF_RUN;
   wire [6:0] pid_sat = sat_half({12'h000, pid_duty});
   wire [6:0] base = ff_hold_ff ? ff_duty_ff : pid_sat;
   logic [6:0] frozen_ff;
   wire [6:0] duty_use = run ? base : frozen_ff; // R17

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         st_ff <= bff_pkg::BFF_RUN;
         reps_cnt_ff <= 4'h0;
         frozen_ff <= 7'h00;
      end else begin
         st_ff <= nxt_st;
         if (run) frozen_ff <= base; // R17
         if (st_ff == bff_pkg::BFF_IDLE && nxt_st == bff_pkg::BFF_BURST)
            reps_cnt_ff <= 4'((5'h01 << reps_ff) - 5'h01); // R18
         else if (tick && st_ff == bff_pkg::BFF_BURST && reps_cnt_ff != 4'h0)
            reps_cnt_ff <= reps_cnt_ff - 4'h1;
      end
   end

   // half-cycle timing in 5 ns units and volt-second products
   logic [9:0] tcnt_ff, t_even_ff;
   logic [11:0] v_even_ff;
   logic signed [27:0] integ_ff;
   logic signed [7:0] corr_ff;
   assign dcm = iout_sense < dcm_thr_ff;
   assign fbal_active = lock_ff & bmode_ff & topo_ff & vmode_ff & ~dcm; // R6 R7 R10
   wire [21:0] vs_e = 22'(v_even_ff * t_even_ff);
   wire [21:0] vs_o = 22'(vin_ff * tcnt_ff);
   wire signed [22:0] vs_d = $signed({1'b0, vs_e}) - $signed({1'b0, vs_o});
   wire signed [10:0] t_d = $signed({1'b0, t_even_ff}) - $signed({1'b0, tcnt_ff});
   wire signed [15:0] err_s = tonly_ff ? 16'(t_d) : 16'(vs_d >>> 8); // R8
   wire signed [27:0] p_term = 28'(err_s * $signed({1'b0, kp_ff}));
   wire signed [27:0] i_next = integ_ff + 28'(err_s * $signed({1'b0, ki_ff}));
   wire signed [27:0] pi_sum = (p_term + i_next) >>> 10;
   wire half_end = ph_ff == 7'(`BFF_HALF - 1);

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         tcnt_ff <= 10'h000;
         t_even_ff <= 10'h000;
         v_even_ff <= 12'h000;
      end else begin
         if (half_end | tick) tcnt_ff <= 10'h000;
         else if (rect_hi_ff) tcnt_ff <= tcnt_ff + 10'(`BFF_TICK); // R4
         if (half_end) begin
            t_even_ff <= tcnt_ff; // R4
            v_even_ff <= vin_ff;
         end
      end
   end

   // PI update once a period; suspended balancing clears the trim and integral
   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         integ_ff <= 28'sh000_0000;
         corr_ff <= 8'sh00;
      end else if (!fbal_active) begin
         integ_ff <= 28'sh000_0000; // R7 R10
         corr_ff <= 8'sh00;
      end else if (tick) begin
         integ_ff <= i_next; // R5
         // signed bounds: an unsigned compare would turn every negative sum into the top clamp
         if (pi_sum > $signed(28'(`BFF_MAXCORR))) corr_ff <= 8'(`BFF_MAXCORR);
         else if (pi_sum < -$signed(28'(`BFF_MAXCORR))) corr_ff <= -8'(`BFF_MAXCORR);
         else corr_ff <= pi_sum[7:0];
      end
   end

   // widths latched at the period edge so a pulse never changes mid-flight
   logic [6:0] w_even_ff, w_odd_ff;
   // a long even half gives a positive error, so the even pulse shrinks and the odd one grows
   wire [6:0] nxt_w_even = sat_half($signed({13'h0000, duty_use}) - 20'(corr_ff)); // R5
   wire [6:0] nxt_w_odd = sat_half($signed({13'h0000, duty_use}) + 20'(corr_ff));
   wire sw = st_ff != bff_pkg::BFF_IDLE; // R12
   wire pe = sw & even & (hp < w_even_ff);
   wire po = sw & ~even & (hp < w_odd_ff);
   logic prim_even_ff, prim_odd_ff, sr_even_ff, sr_odd_ff;

   always_ff @(posedge clk or negedge reset_n) begin
      if (!reset_n) begin
         w_even_ff <= 7'h00;
         w_odd_ff <= 7'h00;
         {prim_even_ff, prim_odd_ff, sr_even_ff, sr_odd_ff} <= 4'h0;
      end else begin
         if (tick) begin
            w_even_ff <= nxt_w_even;
            w_odd_ff <= nxt_w_odd;
         end
         prim_even_ff <= pe;
         prim_odd_ff <= po;
         sr_even_ff <= run & even & (hp >= w_even_ff + 7'(`BFF_DEADTIME)); // R16
         sr_odd_ff <= run & ~even & (hp >= w_odd_ff + 7'(`BFF_DEADTIME)); // R16
      end
   end

   assign avs_readdata = rdata_ff;
   assign avs_waitrequest = wait_ff;
   assign prim_even = prim_even_ff;
   assign prim_odd = prim_odd_ff;
   assign sr_even = sr_even_ff;
   assign sr_odd = sr_odd_ff;
   assign burst_enable = burst_en_ff;

   // a burst opens from idle and carries the code's cycle count less one
   sequence s_restart;
      st_ff == bff_pkg::BFF_IDLE && tick && burst_en_ff && restart;
   endsequence
   sequence s_burst_loaded;
      st_ff == bff_pkg::BFF_BURST && reps_cnt_ff == 4'((5'h01 << reps_ff) - 5'h01);
   endsequence

   a_bus_wait_one: assert property (req && wait_ff |=> !wait_ff && $past(rd_mux) == rdata_ff)
      else $error("bus answer not after one wait cycle");
   a_src_override: assert property (src_ff == `BFF_SRC_OVR |=> vin_ff == $past(ovr_ff)) // R2
      else $error("override source not selected");
   a_burst_entry: assert property (run && tick && burst_en_ff && low_i |=> st_ff == bff_pkg::BFF_IDLE) // R12
      else $error("burst entry missed");
   a_idle_quiet: assert property (st_ff == bff_pkg::BFF_IDLE |=> !prim_even && !prim_odd) // R12
      else $error("switching while burst idle");
   a_restart_cnt: assert property (s_restart |=> s_burst_loaded) // R18
      else $error("burst restart or cycle count wrong");
   a_sr_burst_off: assert property (!run |=> !sr_even && !sr_odd) // R16
      else $error("rectifier on in burst");
   a_duty_frozen: assert property (!run && $past(!run) |-> $stable(frozen_ff)) // R17
      else $error("frozen duty moved");
   a_lock_no_trim: assert property (!lock_ff |=> corr_ff == 8'sh00 && integ_ff == 28'sh000_0000) // R7
      else $error("trim applied without duty lock");
   a_no_burst_run: assert property (!burst_en_ff && tick |=> run) // R19
      else $error("burst state while burst disabled");
   a_ff_divider: assert property (div_start |-> ##19 ff_hold_ff) // R3
      else $error("feed-forward duty not applied");
   a_dcm_suspend: assert property (dcm |=> corr_ff == 8'sh00 && integ_ff == 28'sh000_0000) // R10
      else $error("balancing trim applied in discontinuous conduction");
   a_burst_quit: assert property (st_ff == bff_pkg::BFF_BURST && tick && !burst_en_ff |=> run) // R19
      else $error("burst kept running after burst mode was disabled");
endmodule : bff_burst_fluxbal_ff

/* File: bff_burst_fluxbal_ff_tb.sv */
`timescale 1ns/1ps
`include "bff_consts.svh"
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin fail_count++; \
   $display("mismatch t=%0t got=%0h exp=%0h", $time, g, e); end end
module bff_burst_fluxbal_ff_tb;
   logic clk, reset_n, avs_read, avs_write, avs_waitrequest;
   logic prim_even, prim_odd, sr_even, sr_odd, burst_enable, rect_edge_cmp, pe_q, po_q;
   logic [4:0] avs_address;
   logic [31:0] avs_writedata, avs_readdata, rd;
   logic [11:0] vin_a, vin_b, vin_pri, vout, iout, ra, rb, rp, vs, is;
   logic [11:0] vals [4];
   logic [7:0] pid_duty, seed, d;
   int fail_count, n_tests, cyc, pe_r, po_r, pe_h, sr_h, s_pr, s_po, s_ph, s_sr, w;
   bff_burst_fluxbal_ff uut (.clk(clk), .reset_n(reset_n), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .rect_sense_pin_a(ra), .rect_sense_pin_b(rb),
      .primary_vin_sense_pin(rp), .vout_sense_pin(vs), .iout_sense(is), .rect_edge_cmp(rect_edge_cmp),
      .pid_duty(pid_duty), .prim_even(prim_even), .prim_odd(prim_odd), .sr_even(sr_even),
      .sr_odd(sr_odd), .burst_enable(burst_enable));
   bff_power_stage stage (.clk(clk), .prim_even(prim_even), .prim_odd(prim_odd), .vin_a(vin_a),
      .vin_b(vin_b), .vin_pri(vin_pri), .vout(vout), .iout(iout), .rect_sense_pin_a(ra),
      .rect_sense_pin_b(rb), .primary_vin_sense_pin(rp), .vout_sense_pin(vs), .iout_sense(is),
      .rect_edge_cmp(rect_edge_cmp));
   // free-running clock at 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   // gate activity tallies; tests take differences so nothing ever needs clearing
   always @(posedge clk) begin
      pe_q <= prim_even;
      po_q <= prim_odd;
      pe_r <= pe_r + int'(prim_even === 1'b1 && pe_q === 1'b0);
      po_r <= po_r + int'(prim_odd === 1'b1 && po_q === 1'b0);
      pe_h <= pe_h + int'(prim_even === 1'b1);
      sr_h <= sr_h + int'(sr_even !== 1'b0 || sr_odd !== 1'b0);
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         fail_count++;
         end_sim();
      end
   end
   function automatic logic [7:0] lfsr_next(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction : lfsr_next
   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_sim
   // one access: hold everything until waitrequest is seen low at an edge, then release
   task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] dat);
      avs_address <= a;
      avs_writedata <= dat;
      avs_write <= wr;
      avs_read <= ~wr;
      @(posedge clk);
      while (avs_waitrequest !== 1'b0) @(posedge clk);
      rd = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic snap();
      s_pr = pe_r;
      s_po = po_r;
      s_ph = pe_h;
      s_sr = sr_h;
   endtask : snap
   initial begin
      cyc = 0; pe_r = 0; po_r = 0; pe_h = 0; sr_h = 0; fail_count = 0; n_tests = 0;
      reset_n = 1'b0; avs_read = 1'b0; avs_write = 1'b0; avs_address = 5'h00; avs_writedata = 32'h0;
      seed = 8'h56;
      for (int i = 0; i < 4; i++) begin
         seed = lfsr_next(seed);
         vals[i] = {2'(i) + 2'h1, 2'h0, seed};
      end
      seed = lfsr_next(seed);
      d = 8'h0A + 8'(seed % 30);
      vin_a = vals[0]; vin_b = vals[1]; vin_pri = vals[2];
      vout = 12'h800; iout = 12'h100; pid_duty = d;
      repeat (12) @(posedge clk);
      reset_n <= 1'b1;
      @(posedge clk);
      // reset values and an address with no register behind it
      bus(1'b0, `BFF_OFF_CTRL, 32'h0); `CHK(rd, 32'h0)
      bus(1'b0, `BFF_OFF_PMODE, 32'h0); `CHK(rd, 32'h1)
      bus(1'b0, 5'h01, 32'h0); `CHK(rd, 32'h0)
      bus(1'b1, `BFF_OFF_GAIN, {16'h0, 8'h18, 8'h04});
      bus(1'b0, `BFF_OFF_GAIN, 32'h0); `CHK(rd, 32'h0000_1804)
      bus(1'b1, `BFF_OFF_TARGET, 32'h800);
      bus(1'b1, `BFF_OFF_OVR, {20'h0, vals[3]});
      // every feed-forward source, the measured input shown in status
      for (int s = 3; s >= 0; s--) begin
         bus(1'b1, `BFF_OFF_CTRL, 32'h70 | s);
         repeat (400) @(posedge clk);
         bus(1'b0, `BFF_OFF_STAT, 32'h0); `CHK(rd[27:16], vals[s])
      end
      // balancing unlocked and burst off: full loop width in each half, no trim
      repeat (300) @(posedge clk);
      snap();
      repeat (300) @(posedge clk);
      `CHK(pe_h - s_ph, 3 * int'(d))
      `CHK(po_r - s_po, 3)
      `CHK(sr_h - s_sr, 6 * (`BFF_HALF - `BFF_DEADTIME - int'(d)))
      // time-only balancing against the stage's two-clock-long even half: settles at one clock of trim
      bus(1'b1, `BFF_OFF_CTRL, 32'h7C);
      repeat (1000) @(posedge clk);
      bus(1'b0, `BFF_OFF_STAT, 32'h0); `CHK(rd[4:3], 2'h2)
      snap();
      repeat (300) @(posedge clk);
      `CHK(pe_h - s_ph, 3 * (int'(d) - 1))
      // load below the discontinuous-conduction threshold drops the trim
      bus(1'b1, `BFF_OFF_DCM, 32'h200);
      repeat (300) @(posedge clk);
      bus(1'b0, `BFF_OFF_STAT, 32'h0); `CHK(rd[4:3], 2'h1)
      snap();
      repeat (300) @(posedge clk);
      `CHK(pe_h - s_ph, 3 * int'(d))
      bus(1'b1, `BFF_OFF_DCM, 32'h0);
      bus(1'b1, `BFF_OFF_CTRL, 32'h5C);
      bus(1'b0, `BFF_OFF_STAT, 32'h0); `CHK(rd[4:3], 2'h0)
      bus(1'b1, `BFF_OFF_BURST, 32'h0F40);
      iout <= 12'h010;
      repeat (300) @(posedge clk);
      bus(1'b0, `BFF_OFF_STAT, 32'h0); `CHK(rd[1:0], 2'h0)
      // entry needs twice the current strictly below the threshold code
      iout <= 12'h020;
      bus(1'b1, `BFF_OFF_PMODE, 32'h0);
      @(posedge clk);
      `CHK(burst_enable, 1'b1)
      repeat (300) @(posedge clk);
      bus(1'b0, `BFF_OFF_STAT, 32'h0); `CHK(rd[2:0], 3'h4)
      iout <= 12'h01F;
      repeat (300) @(posedge clk);
      bus(1'b0, `BFF_OFF_STAT, 32'h0); `CHK(rd[2:0], 3'h5)
      for (int n = 0; n < 4; n++) begin
         bus(1'b1, `BFF_OFF_BURST, {18'h0, 2'(n), 4'hF, 8'h40});
         // error equal to the full-scale threshold must not restart
         vout <= 12'h800 - 12'h00F;
         snap();
         repeat (400) @(posedge clk);
         `CHK(pe_r - s_pr, 0)
         seed = lfsr_next(seed);
         pid_duty <= 8'h0A + 8'(seed % 30);
         vout <= 12'h7F0;
         w = 0;
         while (pe_r == s_pr && w < 400) begin
            @(posedge clk);
            w++;
         end
         vout <= 12'h800;
         repeat (1200) @(posedge clk);
         `CHK(pe_r - s_pr, 1 << n)
         `CHK(po_r - s_po, 1 << n)
         `CHK(pe_h - s_ph, (1 << n) * int'(d))
         `CHK(sr_h - s_sr, 0)
      end
      // leaving burst mode returns to steady switching
      bus(1'b1, `BFF_OFF_PMODE, 32'h1);
      repeat (4) @(posedge clk);
      `CHK(burst_enable, 1'b0)
      repeat (400) @(posedge clk);
      snap();
      repeat (300) @(posedge clk);
      `CHK(po_r - s_po, 3)
      bus(1'b0, `BFF_OFF_STAT, 32'h0); `CHK(rd[2:0], 3'h0)
      end_sim();
   end
endmodule : bff_burst_fluxbal_ff_tb

/* File: bff_consts.svh */
// Behaviour
// R1 - feed-forward input voltage comes from one of four selectable sources
// R2 - override source uses the firmware override word, 1.25 mV per LSB scaled
// R3 - input voltage transient recomputes duty in hardware, bypassing the feedback loop
// R4 - each switching cycle measure rectified voltage and half-cycle times at 5 ns
// R5 - volt-second difference of half-cycles drives a PI that trims PWM timings
// R6 - flux balancing only for full-bridge topology in voltage-mode control
// R7 - balancing acts only while duty_lock_flag is 1, otherwise no correction
// R8 - time_only_balance picks timing-only or full volt-second balancing
// R9 - host programs gains 4 and 24, balance mode and duty lock
// R10 - balancing suspended below the discontinuous-conduction threshold
// R11 - power mode command written 0 makes the device raise burst_enable
// R12 - with burst enabled, switching stops when load current falls below threshold
// R13 - entry threshold LSB is half the current sense gain
// R14 - in burst, restart when target minus sensed output exceeds error threshold
// R15 - error threshold LSB 1.25 mV, range zero to 18.75 mV
// R16 - synchronous rectifiers stay off during burst operation
// R17 - duty frozen at its last value on burst entry
// R18 - each burst emits 1, 2, 4 or 8 even/odd cycles by code
// R19 - burst disabled means continuous switching, thresholds ignored
`ifndef BFF_CONSTS_SVH
`define BFF_CONSTS_SVH
`define BFF_OFF_CTRL 5'h00
`define BFF_OFF_PMODE 5'h04
`define BFF_OFF_OVR 5'h08
`define BFF_OFF_GAIN 5'h0C
`define BFF_OFF_BURST 5'h10
`define BFF_OFF_TARGET 5'h14
`define BFF_OFF_DCM 5'h18
`define BFF_OFF_STAT 5'h1C
`define BFF_CTRL_SRC 1:0
`define BFF_CTRL_LOCK 2
`define BFF_CTRL_TONLY 3
`define BFF_CTRL_BMODE 4
`define BFF_CTRL_TOPO_FB 5
`define BFF_CTRL_VMODE 6
`define BFF_BURST_ITH 7:0
`define BFF_BURST_ERR 11:8
`define BFF_BURST_REPS 13:12
`define BFF_PMODE_RST 8'h01
`define BFF_PMODE_BURST 8'h00
`define BFF_PMBUS_POWER_MODE 8'h34
`define BFF_SRC_A 2'h0
`define BFF_SRC_B 2'h1
`define BFF_SRC_PRI 2'h2
`define BFF_SRC_OVR 2'h3
`define BFF_OVR_LSB_UV 1250
`define BFF_ERR_LSB_UV 1250
`define BFF_ERR_MAX_UV 18750
`define BFF_CLK_NS 40
`define BFF_RES_NS 5
`define BFF_TICK (`BFF_CLK_NS / `BFF_RES_NS)
`define BFF_CLK_KHZ 25000
`define BFF_FSW_KHZ 250
`define BFF_PERIOD (`BFF_CLK_KHZ / `BFF_FSW_KHZ)
`define BFF_HALF (`BFF_PERIOD / 2)
`define BFF_DEADTIME 2
`define BFF_FF_TRANS_THR 12'h020
`define BFF_MAXCORR 8
`define BFF_DIV_STEPS 5'h12
`endif

/* File: bff_pkg.sv */
package bff_pkg;
   typedef enum logic [1:0] {BFF_RUN, BFF_IDLE, BFF_BURST} bff_state_t;
endpackage : bff_pkg

/* File: bff_power_stage.sv */
`timescale 1ns/1ps
module bff_power_stage (
   input wire logic clk,
   input wire logic prim_even,
   input wire logic prim_odd,
   input wire logic [11:0] vin_a,
   input wire logic [11:0] vin_b,
   input wire logic [11:0] vin_pri,
   input wire logic [11:0] vout,
   input wire logic [11:0] iout,
   output logic [11:0] rect_sense_pin_a,
   output logic [11:0] rect_sense_pin_b,
   output logic [11:0] primary_vin_sense_pin,
   output logic [11:0] vout_sense_pin,
   output logic [11:0] iout_sense,
   output logic rect_edge_cmp
);
   logic edge_ff, ev1_ff, ev2_ff;
   // sense converters sample every clock, so a step shows one clock late, as on the board
   always_ff @(posedge clk) begin
      rect_sense_pin_a <= vin_a;
      rect_sense_pin_b <= vin_b;
      primary_vin_sense_pin <= vin_pri;
      vout_sense_pin <= vout;
      iout_sense <= iout;
      ev1_ff <= prim_even;
      ev2_ff <= ev1_ff;
      edge_ff <= prim_even | ev1_ff | ev2_ff | prim_odd;
   end
   // rectified pulse lags one clock; the even half runs two clocks long, a gate timing mismatch
   assign rect_edge_cmp = edge_ff;
endmodule : bff_power_stage
